// file: hw/clss_pkg.sv
/*
 * Shared constants, types and the opcode decoder of the load, shift and
 * stack instruction group for an 8-bit accumulator core.
 * Assumes one processor clock and a synchronous memory bus whose read data
 * is valid at the end of the cycle in which the address is presented.
 */
// ====================================================================
// Overview of operation
// - Load X register, five modes, page penalty
// - Load Y register, absolute X page penalty
// - Shift right: bit0 to carry, N cleared
// - No-operation: one byte, two cycles, nothing changes
// - OR memory into accumulator, page penalty
// - Push accumulator, flags untouched
// - Push status, three cycles, flags untouched
// - Pull accumulator from top of stack
// - Pull status replaces every flag, four cycles
// - Rotate left through carry, documented cycle counts
package clss_pkg;

  // ==================================================================
  // Memory map and reset values
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] P_RESET = 8'h20;
  // Bits 5 and 4 read as one in the pushed copy of the status
  localparam logic [7:0] PUSH_STATUS_SET = 8'h30;

  // ==================================================================
  // Status bit positions
  localparam int P_C = 0;
  localparam int P_Z = 1;
  localparam int P_N = 7;

  // ==================================================================
  // Opcodes of the group
  localparam logic [7:0] OP_LIX_IMM = 8'hA2;
  localparam logic [7:0] OP_LIX_ZP = 8'hA6;
  localparam logic [7:0] OP_LIX_ZPY = 8'hB6;
  localparam logic [7:0] OP_LIX_ABS = 8'hAE;
  localparam logic [7:0] OP_LIX_ABSY = 8'hBE;
  localparam logic [7:0] OP_LIY_IMM = 8'hA0;
  localparam logic [7:0] OP_LIY_ZP = 8'hA4;
  localparam logic [7:0] OP_LIY_ZPX = 8'hB4;
  localparam logic [7:0] OP_LIY_ABS = 8'hAC;
  localparam logic [7:0] OP_LIY_ABSX = 8'hBC;
  localparam logic [7:0] OP_SRL_ACC = 8'h4A;
  localparam logic [7:0] OP_SRL_ZP = 8'h46;
  localparam logic [7:0] OP_SRL_ZPX = 8'h56;
  localparam logic [7:0] OP_SRL_ABS = 8'h4E;
  localparam logic [7:0] OP_SRL_ABSX = 8'h5E;
  localparam logic [7:0] OP_NOP = 8'hEA;
  localparam logic [7:0] OP_ORM_IMM = 8'h09;
  localparam logic [7:0] OP_ORM_ZP = 8'h05;
  localparam logic [7:0] OP_ORM_ZPX = 8'h15;
  localparam logic [7:0] OP_ORM_ABS = 8'h0D;
  localparam logic [7:0] OP_ORM_ABSX = 8'h1D;
  localparam logic [7:0] OP_ORM_ABSY = 8'h19;
  localparam logic [7:0] OP_ORM_INDX = 8'h01;
  localparam logic [7:0] OP_ORM_INDY = 8'h11;
  localparam logic [7:0] OP_PSA = 8'h48;
  localparam logic [7:0] OP_PSS = 8'h08;
  localparam logic [7:0] OP_PUA = 8'h68;
  localparam logic [7:0] OP_PUS = 8'h28;
  localparam logic [7:0] OP_RCL_ACC = 8'h2A;
  localparam logic [7:0] OP_RCL_ZP = 8'h26;
  localparam logic [7:0] OP_RCL_ZPX = 8'h36;
  localparam logic [7:0] OP_RCL_ABS = 8'h2E;
  localparam logic [7:0] OP_RCL_ABSX = 8'h3E;
  localparam logic [7:0] OP_RCR_ACC = 8'h6A;
  localparam logic [7:0] OP_RCR_ZP = 8'h66;
  localparam logic [7:0] OP_RCR_ZPX = 8'h76;
  localparam logic [7:0] OP_RCR_ABS = 8'h6E;
  localparam logic [7:0] OP_RCR_ABSX = 8'h7E;

  // ==================================================================
  // Types
  typedef enum logic [3:0] {
    K_LIX, K_LIY, K_SRL, K_NOP, K_ORM, K_PSA, K_PSS, K_PUA, K_PUS,
    K_RCL, K_RCR, K_BAD
  } clss_kind_e;
  typedef enum logic [3:0] {
    M_IMP, M_ACC, M_IMM, M_ZP, M_ZPX, M_ZPY, M_ABS, M_ABSX, M_ABSY,
    M_INDX, M_INDY
  } clss_mode_e;
  typedef enum logic [2:0] {A_PASS, A_OR, A_SRL, A_RCL, A_RCR} clss_aluop_e;
  // Decoded instruction
  typedef struct packed {
    clss_kind_e kind;
    clss_mode_e mode;
  } clss_dec_s;
  // Memory bus request, driven from flip-flops
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
  } clss_bus_s;

  // Opcode to kind and addressing mode; unknown codes decode as K_BAD
  function automatic clss_dec_s clss_decode(input logic [7:0] opc);
    clss_dec_s d;
    d = '{kind: K_BAD, mode: M_IMP};
    case (opc)
      OP_LIX_IMM: d = '{K_LIX, M_IMM};
      OP_LIX_ZP: d = '{K_LIX, M_ZP};
      OP_LIX_ZPY: d = '{K_LIX, M_ZPY};
      OP_LIX_ABS: d = '{K_LIX, M_ABS};
      OP_LIX_ABSY: d = '{K_LIX, M_ABSY};
      OP_LIY_IMM: d = '{K_LIY, M_IMM};
      OP_LIY_ZP: d = '{K_LIY, M_ZP};
      OP_LIY_ZPX: d = '{K_LIY, M_ZPX};
      OP_LIY_ABS: d = '{K_LIY, M_ABS};
      OP_LIY_ABSX: d = '{K_LIY, M_ABSX};
      OP_SRL_ACC: d = '{K_SRL, M_ACC};
      OP_SRL_ZP: d = '{K_SRL, M_ZP};
      OP_SRL_ZPX: d = '{K_SRL, M_ZPX};
      OP_SRL_ABS: d = '{K_SRL, M_ABS};
      OP_SRL_ABSX: d = '{K_SRL, M_ABSX};
      OP_NOP: d = '{K_NOP, M_IMP};
      OP_ORM_IMM: d = '{K_ORM, M_IMM};
      OP_ORM_ZP: d = '{K_ORM, M_ZP};
      OP_ORM_ZPX: d = '{K_ORM, M_ZPX};
      OP_ORM_ABS: d = '{K_ORM, M_ABS};
      OP_ORM_ABSX: d = '{K_ORM, M_ABSX};
      OP_ORM_ABSY: d = '{K_ORM, M_ABSY};
      OP_ORM_INDX: d = '{K_ORM, M_INDX};
      OP_ORM_INDY: d = '{K_ORM, M_INDY};
      OP_PSA: d = '{K_PSA, M_IMP};
      OP_PSS: d = '{K_PSS, M_IMP};
      OP_PUA: d = '{K_PUA, M_IMP};
      OP_PUS: d = '{K_PUS, M_IMP};
      OP_RCL_ACC: d = '{K_RCL, M_ACC};
      OP_RCL_ZP: d = '{K_RCL, M_ZP};
      OP_RCL_ZPX: d = '{K_RCL, M_ZPX};
      OP_RCL_ABS: d = '{K_RCL, M_ABS};
      OP_RCL_ABSX: d = '{K_RCL, M_ABSX};
      OP_RCR_ACC: d = '{K_RCR, M_ACC};
      OP_RCR_ZP: d = '{K_RCR, M_ZP};
      OP_RCR_ZPX: d = '{K_RCR, M_ZPX};
      OP_RCR_ABS: d = '{K_RCR, M_ABS};
      OP_RCR_ABSX: d = '{K_RCR, M_ABSX};
      default: d = '{K_BAD, M_IMP};
    endcase
    return d;
  endfunction

endpackage

// file: hw/clss_alu.sv
/*
 * Result and flag unit: pass, OR, logical shift right and the two
 * rotates through carry. Purely combinational.
 * Assumes the caller picks the operand and decides which result it keeps.
 */
`timescale 1ns/10ps
module clss_alu (
  // Operation select
  input clss_pkg::clss_aluop_e op,
  // Operands
  input logic [7:0] acc,
  input logic [7:0] din,
  input logic cin,
  // Result and flags
  output logic [7:0] dout,
  output logic cout,
  output logic neg,
  output logic zero
);

  // ==================================================================
  // Operation
  // Carry passes through unless a shift or rotate replaces it
  always_comb begin
    dout = din;
    cout = cin;
    case (op)
      clss_pkg::A_OR: dout = acc | din;
      // Zero enters bit 7, so the negative flag always comes out clear
      clss_pkg::A_SRL: begin
        dout = {1'b0, din[7:1]};
        cout = din[0];
      end
      clss_pkg::A_RCL: begin
        dout = {din[6:0], cin};
        cout = din[7];
      end
      clss_pkg::A_RCR: begin
        dout = {cin, din[7:1]};
        cout = din[0];
      end
      default: dout = din;
    endcase
  end

  // Flags from the result
  assign neg = dout[7];
  assign zero = (dout == 8'h00);

endmodule

// file: hw/clss_core.sv
/*
 * Fetches and executes the load, shift, OR, no-operation and stack
 * instruction group, one bus cycle per clock.
 * Assumes memory on the same clock: the address and write strobe are
 * presented for one cycle, and read data is valid at that cycle's end.
 * Opcodes outside the group retire as two-cycle no-operations and pulse
 * illegal_opcode.
 */
`timescale 1ns/10ps
module clss_core #(
  parameter logic [15:0] RESET_PC = clss_pkg::PC_RESET
) (
  // Clock and reset
  input logic clk,
  input logic rst_b,
  // Memory bus
  input logic [7:0] mem_rdata,
  output clss_pkg::clss_bus_s mem_bus,
  // Architectural state
  output logic [7:0] reg_a,
  output logic [7:0] reg_x,
  output logic [7:0] reg_y,
  output logic [7:0] reg_p,
  output logic [7:0] reg_sp,
  output logic [15:0] reg_pc,
  // Status pulses
  output logic instr_done,
  output logic illegal_opcode
);

  // ==================================================================
  // Declarations
  typedef enum logic [3:0] {
    S_FETCH, S_OP1, S_OP2, S_ZPIDX, S_PTRLO, S_PTRHI, S_FIX, S_READ,
    S_DUMMYW, S_WRITE, S_STKDUM, S_PUSH, S_PULL
  } clss_state_e;

  logic rst_meta; // First reset stage, read only by rst_sync_b
  logic rst_sync_b; // Released reset for the rest of the block
  clss_state_e state, next_state;
  clss_pkg::clss_dec_s ins, next_ins; // Instruction in flight
  clss_pkg::clss_bus_s next_bus;
  logic [15:0] ea, next_ea; // Effective address
  logic [7:0] ptr, next_ptr; // Zero-page pointer for indirect modes
  logic [7:0] opnd, next_opnd; // Held operand of read-modify-write
  logic [7:0] next_a, next_x, next_y, next_p, next_sp;
  logic [15:0] next_pc;
  logic next_done, next_illegal;

  // ==================================================================
  // Decode helpers
  wire clss_pkg::clss_dec_s fetched = clss_pkg::clss_decode(mem_rdata);
  wire is_shift = (ins.kind == clss_pkg::K_SRL) || (ins.kind == clss_pkg::K_RCL)
    || (ins.kind == clss_pkg::K_RCR);
  wire is_rmw = is_shift && (ins.mode != clss_pkg::M_ACC);
  // Y indexes the Y-indexed forms, X the rest
  wire use_y = (ins.mode == clss_pkg::M_ZPY) || (ins.mode == clss_pkg::M_ABSY)
    || (ins.mode == clss_pkg::M_INDY);
  wire [7:0] idx = use_y ? reg_y : reg_x;
  // Low byte plus index; bit 8 flags a page crossing
  wire [8:0] idx_sum = {1'b0, ea[7:0]} + {1'b0, idx};
  wire [7:0] hi_inc = mem_rdata + 8'h01;
  wire [15:0] stack_top = {clss_pkg::STACK_PAGE, reg_sp};
  wire [7:0] sp_inc = reg_sp + 8'h01;
  wire [15:0] pc_inc = reg_pc + 16'h0001;

  // ALU operand and operation
  wire [7:0] alu_in = (state == S_DUMMYW) ? opnd
    : (ins.mode == clss_pkg::M_ACC) ? reg_a : mem_rdata;
  wire clss_pkg::clss_aluop_e alu_op =
    (ins.kind == clss_pkg::K_ORM) ? clss_pkg::A_OR
    : (ins.kind == clss_pkg::K_SRL) ? clss_pkg::A_SRL
    : (ins.kind == clss_pkg::K_RCL) ? clss_pkg::A_RCL
    : (ins.kind == clss_pkg::K_RCR) ? clss_pkg::A_RCR : clss_pkg::A_PASS;
  logic [7:0] alu_out;
  logic alu_c, alu_n, alu_z;

  clss_alu clss_alu_inst (
    .op(alu_op),
    .acc(reg_a),
    .din(alu_in),
    .cin(reg_p[clss_pkg::P_C]),
    .dout(alu_out),
    .cout(alu_c),
    .neg(alu_n),
    .zero(alu_z)
  );

  // ==================================================================
  // Reset release
  // Asserts at once, releases two edges later to avoid a ragged exit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // ==================================================================
  // Sequencer
  // Each state is one bus cycle; mem_rdata belongs to the current state
  always_comb begin
    next_state = state;
    next_ins = ins;
    next_bus = '{addr: reg_pc, wdata: 8'h00, we: 1'b0};
    next_ea = ea;
    next_ptr = ptr;
    next_opnd = opnd;
    next_a = reg_a;
    next_x = reg_x;
    next_y = reg_y;
    next_p = reg_p;
    next_sp = reg_sp;
    next_pc = reg_pc;
    next_done = 1'b0;
    next_illegal = 1'b0;
    case (state)
      // Opcode fetch
      S_FETCH: begin
        next_ins = fetched;
        next_pc = pc_inc;
        next_bus.addr = pc_inc;
        next_illegal = (fetched.kind == clss_pkg::K_BAD);
        next_state = S_OP1;
      end
      // Second byte; one-byte forms read it and discard it
      S_OP1: begin
        next_state = S_FETCH;
        case (ins.mode)
          clss_pkg::M_IMP, clss_pkg::M_ACC: begin
            if (ins.kind == clss_pkg::K_PSA || ins.kind == clss_pkg::K_PSS) begin
              next_bus = '{addr: stack_top, wdata: reg_a, we: 1'b1};
              if (ins.kind == clss_pkg::K_PSS)
                next_bus.wdata = reg_p | clss_pkg::PUSH_STATUS_SET;
              next_state = S_PUSH;
            end else if (ins.kind == clss_pkg::K_PUA || ins.kind == clss_pkg::K_PUS) begin
              next_bus.addr = stack_top;
              next_state = S_STKDUM;
            end else begin
              // No-operation and unknown codes end here untouched
              next_done = 1'b1;
              if (is_shift) begin
                next_a = alu_out;
                next_p[clss_pkg::P_C] = alu_c;
                next_p[clss_pkg::P_N] = alu_n;
                next_p[clss_pkg::P_Z] = alu_z;
              end
            end
          end
          clss_pkg::M_IMM: begin
            next_pc = pc_inc;
            next_bus.addr = pc_inc;
            next_done = 1'b1;
            if (ins.kind == clss_pkg::K_LIX)
              next_x = alu_out;
            else if (ins.kind == clss_pkg::K_LIY)
              next_y = alu_out;
            else
              next_a = alu_out;
            next_p[clss_pkg::P_N] = alu_n;
            next_p[clss_pkg::P_Z] = alu_z;
          end
          clss_pkg::M_ZP: begin
            next_pc = pc_inc;
            next_ea = {clss_pkg::ZERO_PAGE, mem_rdata};
            next_bus.addr = {clss_pkg::ZERO_PAGE, mem_rdata};
            next_state = S_READ;
          end
          clss_pkg::M_ZPX, clss_pkg::M_ZPY, clss_pkg::M_INDX: begin
            next_pc = pc_inc;
            next_ea = {clss_pkg::ZERO_PAGE, mem_rdata};
            next_bus.addr = {clss_pkg::ZERO_PAGE, mem_rdata};
            next_state = S_ZPIDX;
          end
          clss_pkg::M_INDY: begin
            next_pc = pc_inc;
            next_ptr = mem_rdata;
            next_bus.addr = {clss_pkg::ZERO_PAGE, mem_rdata};
            next_state = S_PTRLO;
          end
          default: begin
            // Absolute forms: low byte now, high byte next
            next_pc = pc_inc;
            next_ea = {8'h00, mem_rdata};
            next_bus.addr = pc_inc;
            next_state = S_OP2;
          end
        endcase
      end
      // Index add inside page zero; the carry is dropped on purpose
      S_ZPIDX: begin
        if (ins.mode == clss_pkg::M_INDX) begin
          next_ptr = idx_sum[7:0];
          next_bus.addr = {clss_pkg::ZERO_PAGE, idx_sum[7:0]};
          next_state = S_PTRLO;
        end else begin
          next_ea = {clss_pkg::ZERO_PAGE, idx_sum[7:0]};
          next_bus.addr = {clss_pkg::ZERO_PAGE, idx_sum[7:0]};
          next_state = S_READ;
        end
      end
      // Pointer low byte; the pointer wraps inside page zero
      S_PTRLO: begin
        next_ea = {8'h00, mem_rdata};
        next_ptr = ptr + 8'h01;
        next_bus.addr = {clss_pkg::ZERO_PAGE, ptr + 8'h01};
        next_state = S_PTRHI;
      end
      // High byte of an absolute or indirect address
      S_OP2, S_PTRHI: begin
        if (state == S_OP2)
          next_pc = pc_inc;
        next_state = S_READ;
        if (ins.mode == clss_pkg::M_ABS || ins.mode == clss_pkg::M_INDX) begin
          next_ea = {mem_rdata, ea[7:0]};
          next_bus.addr = {mem_rdata, ea[7:0]};
        end else begin
          // Uncorrected read first; the fix cycle costs one more clock
          next_ea = {mem_rdata, idx_sum[7:0]};
          next_bus.addr = {mem_rdata, idx_sum[7:0]};
          if (idx_sum[8] || is_rmw) begin
            next_state = S_FIX;
            if (idx_sum[8])
              next_ea = {hi_inc, idx_sum[7:0]};
          end
        end
      end
      // Page fix: dummy read done, now the real address
      S_FIX: begin
        next_bus.addr = ea;
        next_state = S_READ;
      end
      // Operand read
      S_READ: begin
        if (is_rmw) begin
          next_opnd = mem_rdata;
          next_bus = '{addr: ea, wdata: mem_rdata, we: 1'b1};
          next_state = S_DUMMYW;
        end else begin
          next_done = 1'b1;
          next_state = S_FETCH;
          if (ins.kind == clss_pkg::K_LIX)
            next_x = alu_out;
          else if (ins.kind == clss_pkg::K_LIY)
            next_y = alu_out;
          else
            next_a = alu_out;
          next_p[clss_pkg::P_N] = alu_n;
          next_p[clss_pkg::P_Z] = alu_z;
        end
      end
      // Old value written back while the new one is formed
      S_DUMMYW: begin
        next_bus = '{addr: ea, wdata: alu_out, we: 1'b1};
        next_p[clss_pkg::P_C] = alu_c;
        next_p[clss_pkg::P_N] = alu_n;
        next_p[clss_pkg::P_Z] = alu_z;
        next_state = S_WRITE;
      end
      S_WRITE: begin
        next_done = 1'b1;
        next_state = S_FETCH;
      end
      // Push: write done this cycle, stack grows downward
      S_PUSH: begin
        next_sp = reg_sp - 8'h01;
        next_done = 1'b1;
        next_state = S_FETCH;
      end
      // Pull: dummy read of the old top, then read the new top
      S_STKDUM: begin
        next_sp = sp_inc;
        next_bus.addr = {clss_pkg::STACK_PAGE, sp_inc};
        next_state = S_PULL;
      end
      S_PULL: begin
        next_done = 1'b1;
        next_state = S_FETCH;
        if (ins.kind == clss_pkg::K_PUS) begin
          next_p = mem_rdata;
        end else begin
          next_a = alu_out;
          next_p[clss_pkg::P_N] = alu_n;
          next_p[clss_pkg::P_Z] = alu_z;
        end
      end
      default: next_state = S_FETCH;
    endcase
  end

  // ==================================================================
  // State registers
  // Reset starts an opcode fetch at RESET_PC; no vector is read here
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= S_FETCH;
      ins <= '{kind: clss_pkg::K_NOP, mode: clss_pkg::M_IMP};
      mem_bus <= '{addr: RESET_PC, wdata: 8'h00, we: 1'b0};
      ea <= 16'h0000;
      ptr <= 8'h00;
      opnd <= 8'h00;
      reg_a <= 8'h00;
      reg_x <= 8'h00;
      reg_y <= 8'h00;
      reg_p <= clss_pkg::P_RESET;
      reg_sp <= clss_pkg::SP_RESET;
      reg_pc <= RESET_PC;
      instr_done <= 1'b0;
      illegal_opcode <= 1'b0;
    end else begin
      state <= next_state;
      ins <= next_ins;
      mem_bus <= next_bus;
      ea <= next_ea;
      ptr <= next_ptr;
      opnd <= next_opnd;
      reg_a <= next_a;
      reg_x <= next_x;
      reg_y <= next_y;
      reg_p <= next_p;
      reg_sp <= next_sp;
      reg_pc <= next_pc;
      instr_done <= next_done;
      illegal_opcode <= next_illegal;
    end
  end

endmodule

// file: sim/clss_mem_model.sv
/*
 * Zero-wait-state system memory on the processor bus, 64 KiB of bytes.
 * Assumes the bench fills the array before reset is released.
 */
`timescale 1ns/10ps
module clss_mem_model (
  // Clock
  input logic clk,
  // Bus from the core
  input clss_pkg::clss_bus_s mem_bus,
  output logic [7:0] mem_rdata
);
  // ==================================================================
  // Storage
  logic [7:0] mem [0:65535]; // Whole address space, no holes

  // Read data follows the address within the same cycle
  assign mem_rdata = mem[mem_bus.addr];

  // Writes land at the edge that ends the write cycle
  always @(posedge clk) begin
    if (mem_bus.we) begin
      mem[mem_bus.addr] <= mem_bus.wdata;
    end
  end
endmodule

// file: sim/clss_core_assertions.sv
/*
 * Timing and result checks on the core's ports.
 * Assumes it is bound into clss_core and sees only its ports.
 */
`timescale 1ns/10ps
module clss_core_assertions (
  // Clock and reset
  input logic clk,
  input logic rst_b,
  // Bus and state
  input logic [7:0] mem_rdata,
  input clss_pkg::clss_bus_s mem_bus,
  input logic [7:0] reg_a,
  input logic [7:0] reg_x,
  input logic [7:0] reg_p,
  input logic [7:0] reg_sp,
  input logic instr_done
);
  // ==================================================================
  // Common clocking; reset masks every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Opcode seen in a fetch cycle
  sequence s_fetch(logic [7:0] op);
    instr_done && mem_rdata == op;
  endsequence
  // Stack write of a given byte at the current top
  sequence s_push(logic [7:0] val);
    mem_bus.we && mem_bus.addr == {clss_pkg::STACK_PAGE, reg_sp} && mem_bus.wdata == val;
  endsequence

  // ==================================================================
  // Properties
  property p_nop;
    s_fetch(8'hEA) |-> ##2 instr_done && reg_a == $past(reg_a, 2) && reg_p == $past(reg_p, 2);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state or cycles");
  property p_ldx_imm;
    s_fetch(8'hA2) |-> ##1 !mem_bus.we ##1 instr_done && reg_x == $past(mem_rdata)
      && reg_p[7] == reg_x[7] && reg_p[1] == (reg_x == 8'h00);
  endproperty
  a_ldx_imm: assert property (p_ldx_imm) else $error("index load wrong");
  property p_ora_imm;
    s_fetch(8'h09) |-> ##2 instr_done && reg_a == ($past(reg_a, 2) | $past(mem_rdata));
  endproperty
  a_ora_imm: assert property (p_ora_imm) else $error("or result wrong");
  property p_lsr_zp;
    s_fetch(8'h46) |-> ##3 mem_bus.we ##1 mem_bus.we && mem_bus.wdata == ($past(mem_bus.wdata) >> 1)
      && reg_p[0] == $past(mem_bus.wdata[0]) && !reg_p[7] ##1 instr_done;
  endproperty
  a_lsr_zp: assert property (p_lsr_zp) else $error("shift right wrong");
  property p_pha;
    s_fetch(8'h48) |-> ##2 s_push(reg_a) ##1 instr_done && reg_p == $past(reg_p, 3);
  endproperty
  a_pha: assert property (p_pha) else $error("push accumulator wrong");
  property p_php;
    s_fetch(8'h08) |-> ##2 s_push(reg_p | clss_pkg::PUSH_STATUS_SET)
      ##1 instr_done && reg_p == $past(reg_p, 3);
  endproperty
  a_php: assert property (p_php) else $error("push status wrong");
  property p_pla;
    s_fetch(8'h68) |-> ##4 instr_done && reg_a == $past(mem_rdata)
      && reg_p[7] == reg_a[7] && reg_p[1] == (reg_a == 8'h00);
  endproperty
  a_pla: assert property (p_pla) else $error("pull accumulator wrong");
  property p_plp;
    s_fetch(8'h28) |-> ##4 instr_done && reg_p == $past(mem_rdata);
  endproperty
  a_plp: assert property (p_plp) else $error("pull status wrong");
  property p_rol_absx;
    s_fetch(8'h3E) |-> ##5 mem_bus.we ##1 mem_bus.we
      && mem_bus.wdata == {$past(mem_bus.wdata[6:0]), $past(reg_p[0])} ##1 instr_done;
  endproperty
  a_rol_absx: assert property (p_rol_absx) else $error("rotate left wrong");
  property p_ror_acc;
    s_fetch(8'h6A) |-> ##2 instr_done && reg_a == {$past(reg_p[0], 2), $past(reg_a[7:1], 2)}
      && reg_p[0] == $past(reg_a[0], 2);
  endproperty
  a_ror_acc: assert property (p_ror_acc) else $error("rotate right wrong");
endmodule

bind clss_core clss_core_assertions clss_core_assertions_inst (
  .clk(clk), .rst_b(rst_b), .mem_rdata(mem_rdata), .mem_bus(mem_bus), .reg_a(reg_a),
  .reg_x(reg_x), .reg_p(reg_p), .reg_sp(reg_sp), .instr_done(instr_done)
);

// file: sim/tb_cpu_load_shift_stack_ops.sv
/*
 * Self-checking bench: runs one program through the core, timing each
 * instruction between done pulses and checking registers and memory.
 * Assumes the core fetches from RESET_PC with zero-wait memory.
 */
`timescale 1ns/10ps
module tb_cpu_load_shift_stack_ops;
  // ==================================================================
  // Signals
  logic clk = 1'b0; // 25 MHz
  logic rst_b = 1'b0; // Held low at start
  logic [7:0] mem_rdata, reg_a, reg_x, reg_y, reg_p, reg_sp;
  logic [15:0] reg_pc;
  logic instr_done, illegal_opcode;
  clss_pkg::clss_bus_s mem_bus;
  int bad_count = 0;
  int num_checks = 0;
  int n_illegal = 0; // Illegal-opcode pulses seen
  // Program at 0x0200 keeps code out of page zero data
  logic [7:0] prog [$] = '{8'hEA, 8'hA2, 8'h80, 8'hBC, 8'h90, 8'h03, 8'hBE, 8'h00, 8'h03,
    8'hA4, 8'h12, 8'h09, 8'h01, 8'h05, 8'h10, 8'h11, 8'h20, 8'h01, 8'hDF, 8'h46, 8'h11,
    8'h4E, 8'h01, 8'h03, 8'hEA, 8'h2A, 8'h3E, 8'hC0, 8'h02, 8'h66, 8'h11, 8'h6A, 8'h48,
    8'h08, 8'h68, 8'h28, 8'h36, 8'hD0, 8'hB6, 8'h0C, 8'h02};
  logic [15:0] d_addr [$] = '{16'h0410, 16'h0300, 16'h0012, 16'h0010, 16'h0020, 16'h0021,
    16'h03F5, 16'h03F0, 16'h0011, 16'h0301};
  logic [7:0] d_val [$] = '{8'h00, 8'h41, 8'h05, 8'h80, 8'hF0, 8'h03, 8'h02, 8'h04, 8'h03,
    8'h80};

  always #20 clk = ~clk;
  // Pulses stand a whole cycle, so the falling edge sees each one once
  always @(negedge clk) if (illegal_opcode === 1'b1) n_illegal++;

  // ==================================================================
  // Design and memory
  clss_core #(.RESET_PC(16'h0200)) clss_core_inst (
    .clk(clk), .rst_b(rst_b), .mem_rdata(mem_rdata), .mem_bus(mem_bus), .reg_a(reg_a),
    .reg_x(reg_x), .reg_y(reg_y), .reg_p(reg_p), .reg_sp(reg_sp), .reg_pc(reg_pc),
    .instr_done(instr_done), .illegal_opcode(illegal_opcode)
  );
  clss_mem_model mem_model_inst (.clk(clk), .mem_bus(mem_bus), .mem_rdata(mem_rdata));

  // ==================================================================
  // Reporting
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Counts cycles up to the next done pulse; a hang ends the run
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (instr_done !== 1'b1 && n < 50);
    if (instr_done !== 1'b1) begin
      chk("done pulse", 16'h0000, 16'h0001);
      end_sim();
    end
  endtask
  // One instruction: cycle count and registers afterwards (N, Z, C only)
  task automatic step(input int cyc, input logic [7:0] a, x, y, nzc);
    int n;
    wait_done(n);
    chk("cycles", 16'(n), 16'(cyc));
    chk("acc", reg_a, a);
    chk("index x", reg_x, x);
    chk("index y", reg_y, y);
    chk("flags", reg_p & 8'h83, nzc);
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_index_loads;
    step(2, 8'h00, 8'h80, 8'h00, 8'h80);
    step(5, 8'h00, 8'h80, 8'h00, 8'h02);
    step(4, 8'h00, 8'h41, 8'h00, 8'h00);
    step(3, 8'h00, 8'h41, 8'h05, 8'h00);
  endtask
  task automatic t_or_acc;
    step(2, 8'h01, 8'h41, 8'h05, 8'h00);
    step(3, 8'h81, 8'h41, 8'h05, 8'h80);
    step(5, 8'h83, 8'h41, 8'h05, 8'h80);
    step(6, 8'h87, 8'h41, 8'h05, 8'h80);
  endtask
  task automatic t_shift_nop;
    step(5, 8'h87, 8'h41, 8'h05, 8'h01);
    chk("zp byte", mem_model_inst.mem[16'h0011], 8'h01);
    step(6, 8'h87, 8'h41, 8'h05, 8'h00);
    chk("abs byte", mem_model_inst.mem[16'h0301], 8'h40);
    step(2, 8'h87, 8'h41, 8'h05, 8'h00);
  endtask
  task automatic t_rotate;
    step(2, 8'h0E, 8'h41, 8'h05, 8'h01);
    step(7, 8'h0E, 8'h41, 8'h05, 8'h80);
    chk("abs byte", mem_model_inst.mem[16'h0301], 8'h81);
    step(5, 8'h0E, 8'h41, 8'h05, 8'h03);
    chk("zp byte", mem_model_inst.mem[16'h0011], 8'h00);
    step(2, 8'h87, 8'h41, 8'h05, 8'h80);
  endtask
  task automatic t_stack;
    step(3, 8'h87, 8'h41, 8'h05, 8'h80);
    chk("stack top", mem_model_inst.mem[16'h01FF], 8'h87);
    step(3, 8'h87, 8'h41, 8'h05, 8'h80);
    chk("pushed status", mem_model_inst.mem[16'h01FE],
      clss_pkg::P_RESET | 8'h80 | clss_pkg::PUSH_STATUS_SET);
    chk("stack ptr", reg_sp, 8'hFD);
    step(4, 8'hB0, 8'h41, 8'h05, 8'h80);
    step(4, 8'hB0, 8'h41, 8'h05, 8'h83);
    chk("status", reg_p, 8'h87);
    chk("stack ptr", reg_sp, 8'hFF);
  endtask
  // Zero-page index wrap, index load through Y, then an unknown opcode
  task automatic t_odd;
    step(6, 8'hB0, 8'h41, 8'h05, 8'h00);
    chk("zp byte", mem_model_inst.mem[16'h0011], 8'h01);
    step(4, 8'hB0, 8'h01, 8'h05, 8'h00);
    step(2, 8'hB0, 8'h01, 8'h05, 8'h00);
    chk("illegal pulses", 16'(n_illegal), 16'h0001);
    chk("pc", reg_pc, 16'h0229);
  endtask

  // ==================================================================
  // Main sequence: fill memory, reset, sync on the first no-op
  initial begin
    int n;
    for (int i = 0; i < 65536; i++) begin
      mem_model_inst.mem[i] = 8'hEA;
    end
    foreach (prog[i]) mem_model_inst.mem[16'h0200 + i] = prog[i];
    foreach (d_addr[i]) mem_model_inst.mem[d_addr[i]] = d_val[i];
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    wait_done(n);
    t_index_loads();
    t_or_acc();
    t_shift_nop();
    t_rotate();
    t_stack();
    t_odd();
    end_sim();
  end
endmodule
